// >>> hw/lcvcg_cnt_if.sv
/*
  lcvcg_cnt_if: command and readout signals between the register file and
  the violation counter bank. Assumes both ends share one clock.
*/
`timescale 1ns/1ns
interface lcvcg_cnt_if;
  logic       clear_all;   // level, forces every counter to zero
  logic       clear_one;   // level, forces the selected counter to zero
  logic       snap_all;    // pulse, copies every counter to its holding word
  logic       snap_one;    // pulse, copies the selected counter
  logic       chan_valid;  // select code names a real channel
  logic [2:0] chan_idx;
  logic       byte_sel;    // 0 low byte, 1 high byte
  logic [7:0] rd_byte;     // registered readout byte

  modport ctrl (output clear_all, clear_one, snap_all, snap_one, chan_valid, chan_idx, byte_sel,
                input rd_byte);
  modport bank (input clear_all, clear_one, snap_all, snap_one, chan_valid, chan_idx, byte_sel,
                output rd_byte);
endinterface : lcvcg_cnt_if

// >>> hw/lcvcg_counter_bank.sv
/*
  lcvcg_counter_bank: per-channel 16-bit line code violation counters, their
  holding words and a registered readout byte. Assumes violation inputs are
  one-cycle pulses synchronous to ref_clk.
*/
`timescale 1ns/1ns
module lcvcg_counter_bank #(
  parameter int NUM_CHAN = 8,
  parameter int COUNT_W  = 16
) (
  input  wire logic                ref_clk,
  input  wire logic                reset_n,
  input  wire logic [NUM_CHAN-1:0] line_code_violation,
  lcvcg_cnt_if.bank                cmd
);
  import lcvcg_pkg::*;

  logic [COUNT_W-1:0] count_r [NUM_CHAN];
  logic [COUNT_W-1:0] count_nxt [NUM_CHAN];
  logic [COUNT_W-1:0] hold_r [NUM_CHAN];
  logic [COUNT_W-1:0] hold_nxt [NUM_CHAN];
  logic [7:0]         rd_byte_r;
  logic [7:0]         rd_byte_nxt;

  // ----------------------------------------------------------------------
  // counters and holding words
  // ----------------------------------------------------------------------
  // counters saturate rather than wrap so a long run never reads as small;
  // they keep counting through a snapshot, only clears stop them
  always_comb
  begin
    for (int i = 0; i < NUM_CHAN; i++)
    begin
      logic match;
      match        = cmd.chan_valid && (cmd.chan_idx == i[2:0]);
      count_nxt[i] = count_r[i];
      hold_nxt[i]  = hold_r[i];
      if (cmd.clear_all || (cmd.clear_one && match))
        count_nxt[i] = '0;
      else if (line_code_violation[i] && (count_r[i] != {COUNT_W{1'b1}}))
        count_nxt[i] = count_r[i] + 1'b1;
      if (cmd.snap_all || (cmd.snap_one && match))
        hold_nxt[i] = count_r[i];
    end
    // readout of the selected holding word, zero when nothing is selected
    rd_byte_nxt = 8'h00;
    if (cmd.chan_valid)
      rd_byte_nxt = cmd.byte_sel ? hold_r[cmd.chan_idx][15:8] : hold_r[cmd.chan_idx][7:0];
  end

  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      for (int i = 0; i < NUM_CHAN; i++)
      begin
        count_r[i] <= '0;
        hold_r[i]  <= '0;
      end
      rd_byte_r <= 8'h00;
    end
    else
    begin
      count_r   <= count_nxt;
      hold_r    <= hold_nxt;
      rd_byte_r <= rd_byte_nxt;
    end
  end

  assign cmd.rd_byte = rd_byte_r;

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);

  clear_all_zero_a: assert property (cmd.clear_all |=> (count_r[0] == '0) && (count_r[NUM_CHAN-1] == '0))
    else $error("counters not zero after clear all");
  snap_all_copy_a: assert property (cmd.snap_all |=> (hold_r[0] == $past(count_r[0]))
                                     && (hold_r[NUM_CHAN-1] == $past(count_r[NUM_CHAN-1])))
    else $error("snapshot did not copy counters");
  hold_stable_a: assert property (!cmd.snap_all && !cmd.snap_one |=> $stable(hold_r[0]))
    else $error("holding word changed without snapshot");
  count_step_a: assert property (line_code_violation[0] && !cmd.clear_all && !cmd.clear_one
                                  && (count_r[0] < 16'h00ff) |=> count_r[0] == $past(count_r[0]) + 16'h0001)
    else $error("violation not counted");
  readout_high_a: assert property (cmd.chan_valid && cmd.byte_sel && $stable(cmd.chan_idx)
                                    |=> rd_byte_r == $past(hold_r[cmd.chan_idx][15:8]))
    else $error("high byte readout wrong");
  readout_none_a: assert property (!cmd.chan_valid |=> rd_byte_r == 8'h00)
    else $error("readout not zero with no channel");

endmodule : lcvcg_counter_bank

// >>> hw/lcvcg_global_ctrl.sv
/*
  lcvcg_global_ctrl: global control registers of an eight-channel line
  interface, reached over classic Wishbone (32-bit data, 8-bit registers in
  the low byte). Selects pin or register sources for transmit enables and
  receive termination, holds the slicer threshold, and commands the
  violation counter bank. Assumes synchronous inputs on ref_clk (125 MHz).
*/
// The implementer's own choice: the Wishbone interface to the registers.
`timescale 1ns/1ns

// What this block does
// - transmit source bit 0 uses per-channel register enables, 1 uses the enable pins
// - termination source bit 0 uses per-channel bits, 1 uses the global pin
// - channel select 0 is none, 1 to 8 are channels 0 to 7
// - channel select also targets single-channel snapshot and clear
// - while clear-all is 1 every counter is forced to zero
// - setting snapshot-all copies every counter into its holding word
// - readout after snapshot shows the selected channel's holding word
// - all global bits, reserved too, read and write and reset to zero
// - byte select picks low byte at 0, high byte at 1
// - eight-bit readout register returns the chosen byte of the selected channel
module lcvcg_global_ctrl #(
  parameter int NUM_CHAN = 8,
  parameter int COUNT_W  = 16,
  parameter int ADDR_W   = 12
) (
  input  wire logic                ref_clk,
  input  wire logic                reset_n,
  // classic Wishbone slave
  input  wire logic                wb_cyc,
  input  wire logic                wb_stb,
  input  wire logic                wb_we,
  input  wire logic [ADDR_W-1:0]   wb_adr,
  input  wire logic [3:0]          wb_sel,
  input  wire logic [31:0]         wb_dat_w,
  output logic      [31:0]         wb_dat_r,
  output logic                     wb_ack,
  // line side
  input  wire logic [NUM_CHAN-1:0] line_code_violation,
  input  wire logic [NUM_CHAN-1:0] chan_tx_enable_bits,
  input  wire logic [NUM_CHAN-1:0] tx_enable_pins,
  input  wire logic [NUM_CHAN-1:0] chan_rx_termination_bits,
  input  wire logic                rx_termination_select,
  output logic      [NUM_CHAN-1:0] tx_output_enable,
  output logic      [NUM_CHAN-1:0] rx_termination_on,
  output logic      [1:0]          slicer_threshold_code,
  output logic      [6:0]          slicer_level_pct
);
  import lcvcg_pkg::*;

  lcvcg_cnt_if cnt_if ();

  logic [7:0]          src_sel_r, src_sel_nxt;
  logic [7:0]          slicer_r, slicer_nxt;
  logic [7:0]          chan_sel_r, chan_sel_nxt;
  logic [7:0]          global_cmd_r, global_cmd_nxt;
  logic                ack_r, ack_nxt;
  logic [31:0]         dat_r_r, dat_r_nxt;
  logic                snap_all_r, snap_all_nxt;
  logic                snap_one_r, snap_one_nxt;
  logic [NUM_CHAN-1:0] tx_en_r, tx_en_nxt;
  logic [NUM_CHAN-1:0] term_r, term_nxt;
  logic [6:0]          pct_r, pct_nxt;
  logic [ADDR_W-3:0]   index;
  logic                wr_take;
  logic                sel_valid;

  // ----------------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------------
  // word index; the write lands on the edge where the master sees ack
  // a write with its low byte lane off is answered but stored nowhere
  assign index     = wb_adr[ADDR_W-1:2];
  assign wr_take   = wb_cyc && wb_stb && wb_we && ack_r && wb_sel[0];
  assign sel_valid = lcvcg_chan_valid(chan_sel_r[3:0]);

  // ----------------------------------------------------------------------
  // register file
  // ----------------------------------------------------------------------
  // every bit, reserved ones included, is stored as written
  always_comb
  begin
    src_sel_nxt    = src_sel_r;
    slicer_nxt     = slicer_r;
    chan_sel_nxt   = chan_sel_r;
    global_cmd_nxt = global_cmd_r;
    if (wr_take)
    begin
      case (index)
        (ADDR_W-2)'(IDX_SRC_SEL):    src_sel_nxt    = wb_dat_w[7:0];
        (ADDR_W-2)'(IDX_SLICER):     slicer_nxt     = wb_dat_w[7:0];
        (ADDR_W-2)'(IDX_CHAN_SEL):   chan_sel_nxt   = wb_dat_w[7:0];
        (ADDR_W-2)'(IDX_GLOBAL_CMD): global_cmd_nxt = wb_dat_w[7:0];
        default:                     ;
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      src_sel_r    <= REG_RESET;
      slicer_r     <= REG_RESET;
      chan_sel_r   <= REG_RESET;
      global_cmd_r <= REG_RESET;
    end
    else
    begin
      src_sel_r    <= src_sel_nxt;
      slicer_r     <= slicer_nxt;
      chan_sel_r   <= chan_sel_nxt;
      global_cmd_r <= global_cmd_nxt;
    end
  end

  // ----------------------------------------------------------------------
  // bus answer
  // ----------------------------------------------------------------------
  // ack one cycle after the request, dropped the cycle after; unmapped
  // addresses are acknowledged with zero data and writes to them ignored
  always_comb
  begin
    ack_nxt   = wb_cyc && wb_stb && !ack_r;
    dat_r_nxt = dat_r_r;
    if (ack_nxt)
    begin
      dat_r_nxt = 32'h0000_0000;
      case (index)
        (ADDR_W-2)'(IDX_SRC_SEL):    dat_r_nxt[7:0] = src_sel_r;
        (ADDR_W-2)'(IDX_SLICER):     dat_r_nxt[7:0] = slicer_r;
        (ADDR_W-2)'(IDX_CHAN_SEL):   dat_r_nxt[7:0] = chan_sel_r;
        (ADDR_W-2)'(IDX_GLOBAL_CMD): dat_r_nxt[7:0] = global_cmd_r;
        (ADDR_W-2)'(IDX_READOUT):    dat_r_nxt[7:0] = cnt_if.rd_byte;
        default:                     dat_r_nxt = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      ack_r   <= 1'b0;
      dat_r_r <= 32'h0000_0000;
    end
    else
    begin
      ack_r   <= ack_nxt;
      dat_r_r <= dat_r_nxt;
    end
  end

  assign wb_ack   = ack_r;
  assign wb_dat_r = dat_r_r;

  // ----------------------------------------------------------------------
  // counter commands
  // ----------------------------------------------------------------------
  // snapshots fire once on the 0 to 1 write so repeated reads of the
  // holding word stay consistent while the bit is left set
  always_comb
  begin
    snap_all_nxt = global_cmd_nxt[SNAP_ALL_BIT] && !global_cmd_r[SNAP_ALL_BIT];
    snap_one_nxt = global_cmd_nxt[SNAP_ONE_BIT] && !global_cmd_r[SNAP_ONE_BIT]
                   && lcvcg_chan_valid(chan_sel_nxt[3:0]);
  end

  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      snap_all_r <= 1'b0;
      snap_one_r <= 1'b0;
    end
    else
    begin
      snap_all_r <= snap_all_nxt;
      snap_one_r <= snap_one_nxt;
    end
  end

  // a single clear is gated by a valid select so code 0 never hits channel 7
  // clears are levels; software keeps them up for the hold time
  assign cnt_if.clear_all  = global_cmd_r[CLEAR_ALL_BIT];
  assign cnt_if.clear_one  = global_cmd_r[CLEAR_ONE_BIT] && sel_valid;
  assign cnt_if.snap_all   = snap_all_r;
  assign cnt_if.snap_one   = snap_one_r;
  assign cnt_if.chan_valid = sel_valid;
  assign cnt_if.chan_idx   = lcvcg_chan_index(chan_sel_r[3:0]);
  assign cnt_if.byte_sel   = global_cmd_r[BYTE_SEL_BIT];

  lcvcg_counter_bank #(
    .NUM_CHAN (NUM_CHAN),
    .COUNT_W  (COUNT_W)
  ) u_bank (
    .ref_clk             (ref_clk),
    .reset_n             (reset_n),
    .line_code_violation (line_code_violation),
    .cmd                 (cnt_if.bank)
  );

  // ----------------------------------------------------------------------
  // line-side controls
  // ----------------------------------------------------------------------
  // sources are muxed then registered, so outputs trail a change by a cycle
  always_comb
  begin
    tx_en_nxt = src_sel_r[TX_SRC_BIT] ? tx_enable_pins : chan_tx_enable_bits;
    term_nxt  = src_sel_r[TERM_SRC_BIT] ? {NUM_CHAN{rx_termination_select}}
                                        : chan_rx_termination_bits;
    pct_nxt   = lcvcg_slicer_pct(slicer_r[SLICER_LSB+1:SLICER_LSB]);
  end

  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      tx_en_r <= '0;
      term_r  <= '0;
      pct_r   <= SLICER_PCT_00;
    end
    else
    begin
      tx_en_r <= tx_en_nxt;
      term_r  <= term_nxt;
      pct_r   <= pct_nxt;
    end
  end

  assign tx_output_enable      = tx_en_r;
  assign rx_termination_on     = term_r;
  assign slicer_threshold_code = slicer_r[SLICER_LSB+1:SLICER_LSB];
  assign slicer_level_pct      = pct_r;

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);

  tx_source_a: assert property (##1 tx_output_enable == $past(src_sel_r[7] ? tx_enable_pins : chan_tx_enable_bits))
    else $error("transmit enable source wrong");
  term_source_a: assert property (src_sel_r[6] && $stable(src_sel_r) |=>
                                   rx_termination_on == {NUM_CHAN{$past(rx_termination_select)}})
    else $error("termination not taken from pin");
  slicer_map_a: assert property (slicer_r[3:2] == 2'b11 && $stable(slicer_r) |=> slicer_level_pct == 7'd55)
    else $error("slicer code 11 not 55 percent");
  reg_readback_a: assert property (wb_cyc && wb_stb && !wb_we && !ack_r && index == 10'h082
                                    |=> wb_ack && wb_dat_r == {24'h000000, src_sel_r})
    else $error("source register readback wrong");
  cmd_gate_a: assert property (cnt_if.clear_one || snap_one_r |->
                                (chan_sel_r[3:0] != 4'h0) && (chan_sel_r[3:0] <= 4'h8))
    else $error("channel command with no channel");
  snap_once_a: assert property (snap_all_r |=> !snap_all_r)
    else $error("snapshot pulse longer than one cycle");
  ack_pulse_a: assert property (wb_ack |=> !wb_ack)
    else $error("ack held two cycles");

  // writes land at the ack edge, and only with the low byte lane on
  wr_land_a: assert property (wr_take && index == (ADDR_W-2)'(IDX_SLICER)
      |=> slicer_r == $past(wb_dat_w[7:0]))
    else $error("slicer write lost");
  lane_off_a: assert property (wb_cyc && wb_stb && wb_we && !wb_sel[0]
      |=> $stable(src_sel_r) && $stable(slicer_r) && $stable(chan_sel_r) && $stable(global_cmd_r))
    else $error("write with lane off changed a register");
  // every answer comes one cycle after the request, mapped or not
  ack_answer_a: assert property (wb_cyc && wb_stb && !wb_ack |=> wb_ack)
    else $error("request not answered next cycle");
  unmapped_read_a: assert property (wb_cyc && wb_stb && !wb_we && !ack_r && index == 10'h040
      |=> wb_dat_r == 32'h0000_0000)
    else $error("unmapped read not zero");
  chan_readback_a: assert property (wb_cyc && wb_stb && !wb_we && !ack_r
      && index == (ADDR_W-2)'(IDX_CHAN_SEL) |=> wb_dat_r == {24'h000000, chan_sel_r})
    else $error("channel select readback wrong");
  readout_map_a: assert property (wb_cyc && wb_stb && !wb_we && !ack_r
      && index == (ADDR_W-2)'(IDX_READOUT) |=> wb_dat_r == {24'h000000, $past(cnt_if.rd_byte)})
    else $error("readout register wrong");

  // every slicer code, not only the odd one out
  slicer_low_a: assert property (slicer_r[3:2] == 2'b00 |=> slicer_level_pct == 7'd60)
    else $error("slicer code 00 not 60 percent");
  slicer_mid_a: assert property (slicer_r[3:2] == 2'b01 |=> slicer_level_pct == 7'd65)
    else $error("slicer code 01 not 65 percent");
  slicer_high_a: assert property (slicer_r[3:2] == 2'b10 |=> slicer_level_pct == 7'd70)
    else $error("slicer code 10 not 70 percent");
  term_bits_a: assert property (!src_sel_r[TERM_SRC_BIT]
      |=> rx_termination_on == $past(chan_rx_termination_bits))
    else $error("termination not taken from register bits");

  // snapshots are issued on the write that sets their bit
  snap_all_fire_a: assert property (wr_take && index == (ADDR_W-2)'(IDX_GLOBAL_CMD) && wb_dat_w[SNAP_ALL_BIT]
      && !global_cmd_r[SNAP_ALL_BIT] |=> snap_all_r)
    else $error("snapshot of all not issued");
  snap_one_fire_a: assert property (wr_take && index == (ADDR_W-2)'(IDX_GLOBAL_CMD) && wb_dat_w[SNAP_ONE_BIT]
      && !global_cmd_r[SNAP_ONE_BIT] && sel_valid |=> snap_one_r)
    else $error("single snapshot not issued");

endmodule : lcvcg_global_ctrl

// >>> hw/lcvcg_pkg.sv
/*
  lcvcg_pkg: register map, field layout, reset values, timing counts and
  shared decode functions of the line code violation global control block.
  Assumes a 125 MHz system clock and a 32-bit classic Wishbone register bus.
*/
package lcvcg_pkg;

  // ----------------------------------------------------------------------
  // register indices (byte address is four times the index)
  // ----------------------------------------------------------------------
  localparam logic [7:0] IDX_SRC_SEL    = 8'h82;
  localparam logic [7:0] IDX_SLICER     = 8'h83;
  localparam logic [7:0] IDX_CHAN_SEL   = 8'h8c;
  localparam logic [7:0] IDX_GLOBAL_CMD = 8'h8d;
  localparam logic [7:0] IDX_READOUT    = 8'h8e;

  // ----------------------------------------------------------------------
  // field positions and reset values
  // ----------------------------------------------------------------------
  localparam int         TX_SRC_BIT     = 7;
  localparam int         TERM_SRC_BIT   = 6;
  localparam int         SLICER_LSB     = 2;
  localparam int         CHAN_SEL_LSB   = 0;
  localparam int         CLEAR_ALL_BIT  = 4;
  localparam int         SNAP_ALL_BIT   = 3;
  localparam int         BYTE_SEL_BIT   = 2;
  localparam int         SNAP_ONE_BIT   = 1;
  localparam int         CLEAR_ONE_BIT  = 0;
  localparam logic [7:0] REG_RESET      = 8'h00;

  // ----------------------------------------------------------------------
  // timing: software holds a counter clear for at least this long
  // ----------------------------------------------------------------------
  localparam int CLK_PERIOD_NS      = 8;
  localparam int CLEAR_HOLD_NS      = 1000;
  localparam int CLEAR_HOLD_CYCLES  = (CLEAR_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // slicer threshold in percent of peak, per code
  localparam logic [6:0] SLICER_PCT_00 = 7'd60;
  localparam logic [6:0] SLICER_PCT_01 = 7'd65;
  localparam logic [6:0] SLICER_PCT_10 = 7'd70;
  localparam logic [6:0] SLICER_PCT_11 = 7'd55;

  // ----------------------------------------------------------------------
  // decode functions
  // ----------------------------------------------------------------------
  // select code 0 means no channel, 1..8 mean channels 0..7
  function automatic logic lcvcg_chan_valid(input logic [3:0] code);
    lcvcg_chan_valid = (code >= 4'h1) && (code <= 4'h8);
  endfunction : lcvcg_chan_valid

  function automatic logic [2:0] lcvcg_chan_index(input logic [3:0] code);
    logic [3:0] idx;
    idx = code - 4'h1;
    lcvcg_chan_index = idx[2:0];
  endfunction : lcvcg_chan_index

  function automatic logic [6:0] lcvcg_slicer_pct(input logic [1:0] code);
    case (code)
      2'b00:   lcvcg_slicer_pct = SLICER_PCT_00;
      2'b01:   lcvcg_slicer_pct = SLICER_PCT_01;
      2'b10:   lcvcg_slicer_pct = SLICER_PCT_10;
      default: lcvcg_slicer_pct = SLICER_PCT_11;
    endcase
  endfunction : lcvcg_slicer_pct

endpackage : lcvcg_pkg

// >>> testbench/tb_lcv_counter_global_control.sv
/*
  tb_lcv_counter_global_control: self-checking bench for lcvcg_global_ctrl.
  Assumes the register map of lcvcg_pkg, a classic Wishbone master in this bench
  and an integer model of the violation counters and their holding words.
*/
`timescale 1ns/1ns
module tb_lcv_counter_global_control;
  import lcvcg_pkg::*;
  // ----------------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------------
  logic        ref_clk = 1'b0;
  logic        reset_n = 1'b0;
  logic        wb_cyc = 1'b0;
  logic        wb_stb = 1'b0;
  logic        wb_we = 1'b0;
  logic [11:0] wb_adr = 12'h000;
  logic [3:0]  wb_sel = 4'h0;
  logic [31:0] wb_dat_w = 32'h0;
  logic [31:0] wb_dat_r;
  logic        wb_ack;
  logic [7:0]  viol = 8'h00;
  logic [7:0]  tx_bits = 8'h00;
  logic [7:0]  tx_pins = 8'h00;
  logic [7:0]  term_bits = 8'h00;
  logic        term_pin = 1'b0;
  logic [7:0]  tx_oe;
  logic [7:0]  term_on;
  logic [1:0]  sl_code;
  logic [6:0]  sl_pct;
  logic        viol_on = 1'b0;
  int          cnt[8];
  int          hold[8];
  int          fails = 0;
  int          checked = 0;
  int          cycles = 0;
  logic [31:0] rdat;
  int          k;
  int          pct_tab[4] = '{60, 65, 70, 55};

  always #4 ref_clk = ~ref_clk;

  lcvcg_global_ctrl u_lcvcg_global_ctrl (
    .ref_clk(ref_clk), .reset_n(reset_n), .wb_cyc(wb_cyc), .wb_stb(wb_stb), .wb_we(wb_we),
    .wb_adr(wb_adr), .wb_sel(wb_sel), .wb_dat_w(wb_dat_w), .wb_dat_r(wb_dat_r), .wb_ack(wb_ack),
    .line_code_violation(viol), .chan_tx_enable_bits(tx_bits), .tx_enable_pins(tx_pins),
    .chan_rx_termination_bits(term_bits), .rx_termination_select(term_pin),
    .tx_output_enable(tx_oe), .rx_termination_on(term_on),
    .slicer_threshold_code(sl_code), .slicer_level_pct(sl_pct));

  // random violation pulses, counted by the model as they are driven
  always @(posedge ref_clk)
  begin
    logic [7:0] v;
    v = viol_on ? 8'($urandom) : 8'h00;
    viol <= v;
    for (int i = 0; i < 8; i++) if (v[i] && cnt[i] < 65535) cnt[i]++;
  end

  // a hang counts as a mismatch; whole run is about 1300 cycles
  always @(posedge ref_clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 30000)
    begin
      fails++;
      end_of_test();
    end
  end

  // ----------------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------------
  task automatic end_of_test();
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : end_of_test

  task automatic chk_rd(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp)
    begin
      fails++;
      $display("ERROR at %0t read exp %h got %h", $time, exp, got);
    end
  endtask : chk_rd

  task automatic chk_out(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp)
    begin
      fails++;
      $display("ERROR at %0t output exp %h got %h", $time, exp, got);
    end
  endtask : chk_out

  // one classic cycle; request held until ack is sampled, then one idle cycle
  task automatic bus(input logic [11:0] a, input logic w, input logic [7:0] d, input logic [3:0] s,
                     output logic [31:0] r);
    @(posedge ref_clk);
    wb_cyc <= 1'b1; wb_stb <= 1'b1; wb_we <= w; wb_adr <= a; wb_sel <= s; wb_dat_w <= {24'h0, d};
    do
      @(posedge ref_clk);
    while (wb_ack !== 1'b1);
    r = wb_dat_r;
    wb_cyc <= 1'b0; wb_stb <= 1'b0; wb_we <= 1'b0;
  endtask : bus

  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    logic [31:0] r;
    bus(a, 1'b1, d, 4'h1, r);
  endtask : wr

  task automatic rd(input logic [11:0] a, output logic [31:0] r);
    bus(a, 1'b0, 8'h00, 4'h1, r);
  endtask : rd

  // select a code, read low then high byte of its held value
  task automatic chk_cnt(input logic [3:0] code, input int exp);
    logic [31:0] r;
    logic [15:0] e;
    e = 16'(exp);
    wr(12'h230, {4'h0, code});
    wr(12'h234, 8'h00);
    repeat (3) @(posedge ref_clk);
    rd(12'h238, r);
    chk_rd(r, {24'h0, e[7:0]});
    wr(12'h234, 8'h04);
    repeat (3) @(posedge ref_clk);
    rd(12'h238, r);
    chk_rd(r, {24'h0, e[15:8]});
  endtask : chk_cnt

  task automatic snap_all();
    wr(12'h234, 8'h08);
    wr(12'h234, 8'h00);
    repeat (3) @(posedge ref_clk);
    foreach (hold[i]) hold[i] = cnt[i];
  endtask : snap_all

  // ----------------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------------
  initial
  begin
    foreach (cnt[i]) cnt[i] = 0;
    void'($urandom(32'h3b2998df));
    repeat (12) @(posedge ref_clk);
    reset_n <= 1'b1;
    // reset values of every register, readout included
    foreach (pct_tab[i])
    begin
      rd(12'h208 + 12'(i * 4 + (i / 2) * 32), rdat);
      chk_rd(rdat, 32'h0);
    end
    rd(12'h238, rdat);
    chk_rd(rdat, 32'h0);
    chk_out({1'b0, sl_pct}, 8'(SLICER_PCT_00));
    // a random value in three registers and e4 in the global command, reserved bits included, write and read back
    for (int a = 0; a < 3; a++)
    begin
      k = $urandom_range(255);
      wr(12'h208 + 12'(a * 4 + (a / 2) * 32), 8'(k));
      rd(12'h208 + 12'(a * 4 + (a / 2) * 32), rdat);
      chk_rd(rdat, 32'(k));
    end
    wr(12'h234, 8'he4);
    rd(12'h234, rdat);
    chk_rd(rdat, 32'he4);
    wr(12'h234, 8'h00);
    // pin or register sources for transmit enable and termination
    for (int s = 0; s < 4; s++)
    begin
      wr(12'h208, 8'(s << 6));
      tx_bits <= 8'($urandom); tx_pins <= 8'($urandom); term_bits <= 8'($urandom); term_pin <= 1'($urandom);
      repeat (3) @(posedge ref_clk);
      chk_out(tx_oe, s[1] ? tx_pins : tx_bits);
      chk_out(term_on, s[0] ? {8{term_pin}} : term_bits);
    end
    // every slicer code
    for (int c = 0; c < 4; c++)
    begin
      wr(12'h20c, 8'(c << 2));
      repeat (3) @(posedge ref_clk);
      chk_out({6'h0, sl_code}, 8'(c));
      chk_out({1'b0, sl_pct}, 8'(pct_tab[c]));
    end
    // count, snapshot, keep counting while every channel is read back
    viol_on <= 1'b1;
    repeat (300) @(posedge ref_clk);
    viol_on <= 1'b0;
    repeat (3) @(posedge ref_clk);
    snap_all();
    viol_on <= 1'b1;
    for (int c = 0; c < 8; c++) chk_cnt(4'(c + 1), hold[c]);
    viol_on <= 1'b0;
    repeat (3) @(posedge ref_clk);
    // codes naming no channel read zero; a snapshot with them does nothing
    foreach (pct_tab[i])
    begin
      wr(12'h230, 8'(i == 0 ? 0 : i * 3 + 6));
      wr(12'h234, 8'h02);
      wr(12'h234, 8'h00);
      repeat (3) @(posedge ref_clk);
      rd(12'h238, rdat);
      chk_rd(rdat, 32'h0);
    end
    chk_cnt(4'h1, hold[0]);
    // single-channel snapshot touches only the selected channel
    k = $urandom_range(7);
    wr(12'h230, 8'(k + 1));
    wr(12'h234, 8'h02);
    wr(12'h234, 8'h00);
    hold[k] = cnt[k];
    chk_cnt(4'(k + 1), hold[k]);
    chk_cnt(4'((k + 1) % 8 + 1), hold[(k + 1) % 8]);
    // single-channel clear
    wr(12'h230, 8'(k + 1));
    wr(12'h234, 8'h01);
    repeat (CLEAR_HOLD_CYCLES) @(posedge ref_clk);
    wr(12'h234, 8'h00);
    cnt[k] = 0;
    snap_all();
    for (int c = 0; c < 8; c++) chk_cnt(4'(c + 1), hold[c]);
    // clear all while violations keep arriving, snapshot taken under clear
    viol_on <= 1'b1;
    wr(12'h234, 8'h10);
    repeat (CLEAR_HOLD_CYCLES) @(posedge ref_clk);
    viol_on <= 1'b0;
    repeat (3) @(posedge ref_clk);
    wr(12'h234, 8'h18);
    wr(12'h234, 8'h00);
    foreach (cnt[i]) cnt[i] = 0;
    for (int c = 0; c < 8; c++) chk_cnt(4'(c + 1), 0);
    // unmapped place and a write with its byte lane off are both dropped
    wr(12'h100, 8'hff);
    rd(12'h100, rdat);
    chk_rd(rdat, 32'h0);
    wr(12'h20c, 8'h5a);
    bus(12'h20c, 1'b1, 8'ha5, 4'h0, rdat);
    rd(12'h20c, rdat);
    chk_rd(rdat, 32'h5a);
    end_of_test();
  end
endmodule : tb_lcv_counter_global_control
